// ==== core/ddpc_top.sv ====
// Device-disable register, two pin configuration registers and the lock pin.
// Assumes an AHB-Lite master on hclk; activate bits and drive selects
// come from logic on hclk, the pins from outside.
`default_nettype none

module ddpc_top (
   // Clock and standby power-on reset.
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   // AHB-Lite slave port.
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata,
   // Activate bits from the logical device configuration.
   input  wire  logic        floppy_activate,
   input  wire  logic        midi_activate,
   input  wire  logic        serial_two_activate,
   input  wire  logic        serial_one_activate,
   input  wire  logic        parallel_activate,
   // Effective device enables.
   output logic              floppy_controller_en,
   output logic              midi_uart_en,
   output logic              serial_port_two_en,
   output logic              serial_port_one_en,
   output logic              parallel_port_en,
   // Floppy write-protect path.
   input  wire  logic        write_protect_n,
   input  wire  logic        drive_select0_n,
   input  wire  logic        drive_select1_n,
   input  wire  logic        force_write_protect,
   output logic              fdc_write_protect_ind,
   // General-purpose pin bank one, bits zero and one.
   input  wire  logic        pin_bank1_bit0_i,
   output logic              pin_bank1_bit0_o,
   output logic              pin_bank1_bit0_oe,
   input  wire  logic        pin_bank1_bit1_i,
   output logic              pin_bank1_bit1_o,
   output logic              pin_bank1_bit1_oe,
   input  wire  logic [1:0]  gpio_out_val,
   output logic [1:0]        gpio_in_val,
   // Joystick one buttons.
   output logic              joy1_button1,
   output logic              joy1_button2,
   // Lock control pin.
   input  wire  logic        lock_control_pin_i,
   output logic              lock_control_pin_o,
   output logic              lock_control_pin_oe,
   input  wire  logic        lock_out_val,
   output logic              lock_in_val
);
   ddpc_regbus_if rb ();

   logic [7:0] dev_disable_reg;
   logic [7:0] pin_cfg0_reg;
   logic [7:0] pin_cfg1_reg;
   logic [7:0] lock_cfg_reg;
   logic       wp_sync1_reg;
   logic       wp_sync2_reg;
   logic       lock_raw;
   logic       locked;
   logic       wp_next;
   logic [7:0] status;
   logic [7:0] levels;

   // =====================================================================
   // Bus slave.
   ddpc_ahb_slave u_slave (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .rb        (rb.slave)
   );

   // =====================================================================
   // Lock condition.
   assign locked = (lock_cfg_reg[ddpc_pkg::LOCK_FUNC_MSB:
                                 ddpc_pkg::LOCK_FUNC_LSB]
                    == ddpc_pkg::LOCK_FUNC_LOCKED)
                && lock_raw;

   // =====================================================================
   // Device-disable register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dev_disable_reg <= ddpc_pkg::RST_DEV_DISABLE;
      end else if (rb.wr_en && rb.wr_idx == ddpc_pkg::IDX_DEV_DISABLE
                   && !locked) begin
         dev_disable_reg <= rb.wr_data
                            & ddpc_pkg::WMASK_DEV_DIS;
      end
   end

   // =====================================================================
   // Pin configuration registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_cfg0_reg <= ddpc_pkg::RST_PIN_CFG;
         pin_cfg1_reg <= ddpc_pkg::RST_PIN_CFG;
         lock_cfg_reg <= ddpc_pkg::RST_PIN_CFG;
      end else if (rb.wr_en) begin
         if (rb.wr_idx == ddpc_pkg::IDX_PIN_CFG0) begin
            pin_cfg0_reg <= rb.wr_data
                            & ddpc_pkg::WMASK_PIN_CFG;
         end
         if (rb.wr_idx == ddpc_pkg::IDX_PIN_CFG1) begin
            pin_cfg1_reg <= rb.wr_data
                            & ddpc_pkg::WMASK_PIN_CFG;
         end
         if (rb.wr_idx == ddpc_pkg::IDX_LOCK_CFG) begin
            lock_cfg_reg <= rb.wr_data
                            & ddpc_pkg::WMASK_LOCK_CFG;
         end
      end
   end

   // =====================================================================
   // Effective device enables.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         floppy_controller_en <= 1'b0;
         midi_uart_en         <= 1'b0;
         serial_port_two_en   <= 1'b0;
         serial_port_one_en   <= 1'b0;
         parallel_port_en     <= 1'b0;
      end else begin
         floppy_controller_en <= floppy_activate
            && !dev_disable_reg[ddpc_pkg::BIT_DIS_FLOPPY];
         midi_uart_en         <= midi_activate
            && !dev_disable_reg[ddpc_pkg::BIT_DIS_MIDI];
         serial_port_two_en   <= serial_two_activate
            && !dev_disable_reg[ddpc_pkg::BIT_DIS_SER2];
         serial_port_one_en   <= serial_one_activate
            && !dev_disable_reg[ddpc_pkg::BIT_DIS_SER1];
         parallel_port_en     <= parallel_activate
            && !dev_disable_reg[ddpc_pkg::BIT_DIS_PAR];
      end
   end

   // =====================================================================
   // Floppy write-protect indication.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_sync1_reg <= 1'b1;
         wp_sync2_reg <= 1'b1;
      end else begin
         wp_sync1_reg <= write_protect_n;
         wp_sync2_reg <= wp_sync1_reg;
      end
   end

   assign wp_next = (drive_select0_n && force_write_protect)
                 || (drive_select1_n && force_write_protect)
                 || wp_sync2_reg
                 || dev_disable_reg[ddpc_pkg::BIT_FLOPPY_WP];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fdc_write_protect_ind <= 1'b1;
      end else begin
         fdc_write_protect_ind <= wp_next;
      end
   end

   // =====================================================================
   // Pins.
   ddpc_pin_cell #(.ALT_EN(1'b1)) u_pin0 (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .cfg      (pin_cfg0_reg),
      .out_val  (gpio_out_val[0]),
      .in_val   (gpio_in_val[0]),
      .alt_val  (joy1_button1),
      .raw_sync (),
      .pin_i    (pin_bank1_bit0_i),
      .pin_o    (pin_bank1_bit0_o),
      .pin_oe   (pin_bank1_bit0_oe)
   );

   ddpc_pin_cell #(.ALT_EN(1'b1)) u_pin1 (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .cfg      (pin_cfg1_reg),
      .out_val  (gpio_out_val[1]),
      .in_val   (gpio_in_val[1]),
      .alt_val  (joy1_button2),
      .raw_sync (),
      .pin_i    (pin_bank1_bit1_i),
      .pin_o    (pin_bank1_bit1_o),
      .pin_oe   (pin_bank1_bit1_oe)
   );

   ddpc_pin_cell #(.ALT_EN(1'b0)) u_lock (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .cfg      (lock_cfg_reg),
      .out_val  (lock_out_val),
      .in_val   (lock_in_val),
      .alt_val  (),
      .raw_sync (lock_raw),
      .pin_i    (lock_control_pin_i),
      .pin_o    (lock_control_pin_o),
      .pin_oe   (lock_control_pin_oe)
   );

   // =====================================================================
   // Read mux.
   assign status = {1'b0, fdc_write_protect_ind, parallel_port_en,
                    serial_port_one_en, serial_port_two_en, midi_uart_en,
                    floppy_controller_en, locked};
   assign levels = {5'h00, lock_raw, gpio_in_val};

   always_comb begin
      case (rb.rd_idx)
         ddpc_pkg::IDX_DEV_DISABLE: rb.rd_data = dev_disable_reg;
         ddpc_pkg::IDX_PIN_CFG0:    rb.rd_data = pin_cfg0_reg;
         ddpc_pkg::IDX_PIN_CFG1:    rb.rd_data = pin_cfg1_reg;
         ddpc_pkg::IDX_LOCK_CFG:    rb.rd_data = lock_cfg_reg;
         ddpc_pkg::IDX_STATUS:      rb.rd_data = status;
         ddpc_pkg::IDX_PIN_LEVELS:  rb.rd_data = levels;
         default:                   rb.rd_data = 8'h00;
      endcase
   end
endmodule : ddpc_top
`default_nettype wire

// ==== core/ddpc_pkg.sv ====
// Shared constants for the device-disable and pin configuration block.
// Assumes a register index bus where the byte address is four times the index.
`default_nettype none
package ddpc_pkg;
   // =====================================================================
   // Register indices.
   localparam logic [7:0] IDX_DEV_DISABLE = 8'h22;
   localparam logic [7:0] IDX_PIN_CFG0    = 8'h23;
   localparam logic [7:0] IDX_PIN_CFG1    = 8'h24;
   localparam logic [7:0] IDX_LOCK_CFG    = 8'h30;
   localparam logic [7:0] IDX_STATUS      = 8'h31;
   localparam logic [7:0] IDX_PIN_LEVELS  = 8'h32;
   // =====================================================================
   // Reset values and writable bit masks.
   localparam logic [7:0] RST_DEV_DISABLE = 8'h00;
   localparam logic [7:0] RST_PIN_CFG     = 8'h01;
   localparam logic [7:0] WMASK_DEV_DIS   = 8'hF9;
   localparam logic [7:0] WMASK_PIN_CFG   = 8'h87;
   localparam logic [7:0] WMASK_LOCK_CFG  = 8'h8F;
   // =====================================================================
   // Field positions.
   localparam int BIT_FLOPPY_WP   = 0;
   localparam int BIT_DIS_FLOPPY  = 3;
   localparam int BIT_DIS_MIDI    = 4;
   localparam int BIT_DIS_SER2    = 5;
   localparam int BIT_DIS_SER1    = 6;
   localparam int BIT_DIS_PAR     = 7;
   localparam int BIT_CFG_DIR     = 0;
   localparam int BIT_CFG_POL     = 1;
   localparam int BIT_CFG_ALT     = 2;
   localparam int BIT_CFG_OTYPE   = 7;
   localparam int LOCK_FUNC_LSB   = 2;
   localparam int LOCK_FUNC_MSB   = 3;
   localparam logic [1:0] LOCK_FUNC_LOCKED = 2'h1;
   // =====================================================================
   // Bus decode.
   localparam int ADDR_IDX_LSB    = 2;
   localparam int ADDR_IDX_MSB    = 9;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum {BUS_IDLE, BUS_WRITE, BUS_RD_WAIT, BUS_RD_DONE} ddpc_bus_t;
endpackage : ddpc_pkg
`default_nettype wire

// ==== core/ddpc_regbus_if.sv ====
// Internal register access path between the bus slave and the register bank.
// Assumes both ends run on the same clock.
`default_nettype none
interface ddpc_regbus_if;
   logic       wr_en;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   logic [7:0] rd_idx;
   logic [7:0] rd_data;
   modport slave (output wr_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
   modport regs  (input wr_en, input wr_idx, input wr_data,
                  input rd_idx, output rd_data);
endinterface : ddpc_regbus_if
`default_nettype wire

// ==== core/ddpc_ahb_slave.sv ====
// AHB-Lite slave that turns word transfers into register index accesses.
// Assumes a single master; writes take no wait state, reads take one.
`default_nettype none
module ddpc_ahb_slave (
   // Clock and reset.
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   // AHB-Lite slave port.
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata,
   // Register side.
   ddpc_regbus_if.slave      rb
);
   ddpc_pkg::ddpc_bus_t state_reg;
   logic [7:0]          idx_reg;
   logic                hit_reg;
   logic                take;
   logic                hit;

   // =====================================================================
   // Address phase decode.
   assign take = hsel && htrans[1] && hready;
   assign hit  = (haddr[31:ddpc_pkg::ADDR_IDX_MSB+1] == '0)
              && (haddr[1:0] == 2'h0) && (hsize == ddpc_pkg::HSIZE_WORD);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ddpc_pkg::BUS_IDLE;
         idx_reg   <= 8'h00;
         hit_reg   <= 1'b0;
      end else begin
         case (state_reg)
            ddpc_pkg::BUS_RD_WAIT: state_reg <= ddpc_pkg::BUS_RD_DONE;
            default: begin
               if (take) begin
                  idx_reg   <= haddr[ddpc_pkg::ADDR_IDX_MSB:
                                     ddpc_pkg::ADDR_IDX_LSB];
                  hit_reg   <= hit;
                  state_reg <= hwrite ? ddpc_pkg::BUS_WRITE
                                      : ddpc_pkg::BUS_RD_WAIT;
               end else begin
                  state_reg <= ddpc_pkg::BUS_IDLE;
               end
            end
         endcase
      end
   end

   // =====================================================================
   // Read data is captured one cycle into the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (state_reg == ddpc_pkg::BUS_RD_WAIT) begin
         hrdata <= hit_reg ? {24'h00_0000, rb.rd_data} : 32'h0000_0000;
      end
   end

   assign hreadyout  = (state_reg != ddpc_pkg::BUS_RD_WAIT);
   assign hresp      = 1'b0;
   assign rb.rd_idx  = idx_reg;
   assign rb.wr_idx  = idx_reg;
   assign rb.wr_data = hwdata[7:0];
   assign rb.wr_en   = (state_reg == ddpc_pkg::BUS_WRITE) && hit_reg;
endmodule : ddpc_ahb_slave
`default_nettype wire

// ==== core/ddpc_pin_cell.sv ====
// One general-purpose pin: synchroniser, polarity, direction, drive type.
// Assumes the output value comes from logic on hclk.
`default_nettype none
module ddpc_pin_cell #(
   parameter bit ALT_EN = 1'b0
) (
   // Clock and reset.
   input  wire  logic       hclk,
   input  wire  logic       hresetn,
   // Configuration and logical values.
   input  wire  logic [7:0] cfg,
   input  wire  logic       out_val,
   output logic             in_val,
   output logic             alt_val,
   output logic             raw_sync,
   // Pin.
   input  wire  logic       pin_i,
   output logic             pin_o,
   output logic             pin_oe
);
   logic sync1_reg;
   logic sync2_reg;
   logic alt;
   logic is_in;
   logic pol;
   logic od;
   logic drive;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_i;
         sync2_reg <= sync1_reg;
      end
   end

   assign alt      = ALT_EN && cfg[ddpc_pkg::BIT_CFG_ALT];
   assign is_in    = cfg[ddpc_pkg::BIT_CFG_DIR] || alt;
   assign pol      = cfg[ddpc_pkg::BIT_CFG_POL];
   assign od       = cfg[ddpc_pkg::BIT_CFG_OTYPE];
   assign drive    = out_val ^ pol;
   assign raw_sync = sync2_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_o   <= 1'b0;
         pin_oe  <= 1'b0;
         in_val  <= 1'b0;
         alt_val <= 1'b1;
      end else begin
         pin_o   <= od ? 1'b0 : drive;
         pin_oe  <= !is_in && (od ? !drive : 1'b1);
         in_val  <= alt ? 1'b0 : (sync2_reg ^ pol);
         alt_val <= alt ? (sync2_reg ^ pol) : 1'b1;
      end
   end
endmodule : ddpc_pin_cell
`default_nettype wire

// ==== verification/ddpc_checker.sv ====
// Port assertions for the device-disable and pin configuration block.
// Assumes it is bound to ddpc_top and sees only its ports, all on hclk.
`default_nettype none
module ddpc_checker (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Bus.
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   // Activate bits and enables.
   input wire logic floppy_activate,
   input wire logic midi_activate,
   input wire logic serial_two_activate,
   input wire logic serial_one_activate,
   input wire logic parallel_activate,
   input wire logic floppy_controller_en,
   input wire logic midi_uart_en,
   input wire logic serial_port_two_en,
   input wire logic serial_port_one_en,
   input wire logic parallel_port_en,
   // Write protect.
   input wire logic drive_select0_n,
   input wire logic drive_select1_n,
   input wire logic force_write_protect,
   input wire logic fdc_write_protect_ind
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // =====================================================================
   // Bus handshake.
   sequence rd_take;
      hsel && htrans[1] && !hwrite && hready;
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   rd_wait_a: assert property (rd_take |=> one_wait)
      else $error("read wait is not exactly one cycle");
   okay_resp_a: assert property (hresp == 1'b0)
      else $error("response is not okay");
   // =====================================================================
   // Enables only follow a set activate bit.
   floppy_en_a: assert property (
      floppy_controller_en |-> $past(floppy_activate))
      else $error("floppy enabled without activate");
   midi_en_a: assert property (
      midi_uart_en |-> $past(midi_activate))
      else $error("midi enabled without activate");
   ser_two_en_a: assert property (
      serial_port_two_en |-> $past(serial_two_activate))
      else $error("serial two enabled without activate");
   ser_one_en_a: assert property (
      serial_port_one_en |-> $past(serial_one_activate))
      else $error("serial one enabled without activate");
   par_en_a: assert property (
      parallel_port_en |-> $past(parallel_activate))
      else $error("parallel enabled without activate");
   // =====================================================================
   // Forced protect with a drive select line high protects.
   wp_force_a: assert property (
      $past(force_write_protect && (drive_select0_n || drive_select1_n))
      |-> fdc_write_protect_ind)
      else $error("forced write protect not shown");
endmodule : ddpc_checker

bind ddpc_top ddpc_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .floppy_activate, .midi_activate,
   .serial_two_activate, .serial_one_activate, .parallel_activate,
   .floppy_controller_en, .midi_uart_en, .serial_port_two_en,
   .serial_port_one_en, .parallel_port_en, .drive_select0_n,
   .drive_select1_n, .force_write_protect, .fdc_write_protect_ind);
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the device-disable and pin configuration block.
// Assumes ddpc_top as the single AHB-Lite slave, clocked at 40 MHz.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hreadyout, hresp, rdy_s, wp_ind, lk_o, lk_oe, lk_in;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] hrdata, rd_s, r;
   logic [4:0]  act = 5'h0;
   wire logic [4:0] en;
   logic        wp_n = 1'b1, ds0 = 1'b1, ds1 = 1'b1, fwp = 1'b0;
   logic        lk_drv = 1'b0;
   logic [1:0]  drv = 2'h0, gout = 2'h0, gin;
   wire logic [1:0] po, poe, joy;
   logic [7:0]  d, c0, c1, cur;
   logic [1:0]  f;
   int          mismatches = 0, compares = 0;
   wire logic [1:0] pin = {poe[1] ? po[1] : drv[1], poe[0] ? po[0] : drv[0]};
   wire logic   lk_pin = lk_oe ? lk_o : lk_drv;
   always #12.5 hclk = ~hclk;
   always @(negedge hclk) begin
      rdy_s <= hreadyout;
      rd_s <= hrdata;
   end
   ddpc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .floppy_activate(act[0]), .midi_activate(act[1]),
      .serial_two_activate(act[2]), .serial_one_activate(act[3]),
      .parallel_activate(act[4]), .floppy_controller_en(en[0]),
      .midi_uart_en(en[1]), .serial_port_two_en(en[2]),
      .serial_port_one_en(en[3]), .parallel_port_en(en[4]),
      .write_protect_n(wp_n), .drive_select0_n(ds0), .drive_select1_n(ds1),
      .force_write_protect(fwp), .fdc_write_protect_ind(wp_ind),
      .pin_bank1_bit0_i(pin[0]), .pin_bank1_bit0_o(po[0]),
      .pin_bank1_bit0_oe(poe[0]), .pin_bank1_bit1_i(pin[1]),
      .pin_bank1_bit1_o(po[1]), .pin_bank1_bit1_oe(poe[1]),
      .gpio_out_val(gout), .gpio_in_val(gin), .joy1_button1(joy[0]),
      .joy1_button2(joy[1]), .lock_control_pin_i(lk_pin),
      .lock_control_pin_o(lk_o), .lock_control_pin_oe(lk_oe),
      .lock_out_val(1'b0), .lock_in_val(lk_in));
   // =====================================================================
   // Bus and comparison tasks.
   task automatic xfer(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'b00};
      hsize <= ddpc_pkg::HSIZE_WORD;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (rdy_s !== 1'b1);
      rd = rd_s;
   endtask : xfer
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   // Expected {oe, o, logical input, joystick} of one bank pin.
   function automatic logic [3:0] pin_exp(input logic [7:0] c,
                                          input logic dv, input logic v);
      logic inp, oe, o, w;
      inp = c[0] | c[2];
      oe = !inp && (c[7] ? !(v ^ c[1]) : 1'b1);
      o = !c[7] && (v ^ c[1]);
      w = oe ? o : dv;
      return {oe, o, c[2] ? 1'b0 : w ^ c[1], c[2] ? w ^ c[1] : 1'b1};
   endfunction : pin_exp
   // =====================================================================
   // Tests.
   initial begin
      #(25 * 6000);
      mismatches++;
      end_sim();
   end
   initial begin
      void'($urandom(32'h0000_8b70));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, ddpc_pkg::IDX_DEV_DISABLE, 8'h00, r);
      chk(r, 32'h0000_0000, "disable reset");
      xfer(1'b0, ddpc_pkg::IDX_PIN_CFG0, 8'h00, r);
      chk(r, 32'h0000_0001, "cfg0 reset");
      xfer(1'b0, ddpc_pkg::IDX_PIN_CFG1, 8'h00, r);
      chk(r, 32'h0000_0001, "cfg1 reset");
      xfer(1'b1, 8'h3F, 8'hFF, r);
      xfer(1'b0, 8'h3F, 8'h00, r);
      chk(r, 32'h0000_0000, "unmapped read");
      for (int i = 0; i < 14; i++) begin
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         c0 = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         c1 = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         act <= 5'($urandom);
         {wp_n, ds0, ds1, fwp} <= 4'($urandom);
         drv <= 2'($urandom);
         gout <= 2'($urandom);
         xfer(1'b1, ddpc_pkg::IDX_DEV_DISABLE, d, r);
         xfer(1'b1, ddpc_pkg::IDX_PIN_CFG0, c0, r);
         xfer(1'b1, ddpc_pkg::IDX_PIN_CFG1, c1, r);
         repeat (5) @(posedge hclk);
         xfer(1'b0, ddpc_pkg::IDX_DEV_DISABLE, 8'h00, r);
         chk(r, {24'h0, d & 8'hF9}, "disable readback");
         xfer(1'b0, ddpc_pkg::IDX_PIN_CFG1, 8'h00, r);
         chk(r, {24'h0, c1 & 8'h87}, "cfg1 readback");
         chk({27'h0, en}, {27'h0, act & ~d[7:3]}, "enables");
         chk({31'h0, wp_ind}, {31'h0, (fwp & (ds0 | ds1)) | wp_n | d[0]},
             "write protect");
         chk({28'h0, poe[0], po[0], gin[0], joy[0]},
             {28'h0, pin_exp(c0, drv[0], gout[0])}, "pin0");
         chk({28'h0, poe[1], po[1], gin[1], joy[1]},
             {28'h0, pin_exp(c1, drv[1], gout[1])},
             "pin1");
      end
      cur = d & 8'hF9;
      for (int i = 0; i < 5; i++) begin
         f = (i == 4) ? 2'h1 : 2'(i);
         lk_drv <= (i < 4);
         xfer(1'b1, ddpc_pkg::IDX_LOCK_CFG, {4'h0, f, 2'b01}, r);
         xfer(1'b0, ddpc_pkg::IDX_LOCK_CFG, 8'h00, r);
         chk(r, {28'h0, f, 2'b01}, "lock cfg");
         repeat (4) @(posedge hclk);
         xfer(1'b0, ddpc_pkg::IDX_STATUS, 8'h00, r);
         chk({31'h0, r[0]}, {31'h0, f == 2'h1 && i < 4}, "locked");
         chk({29'h0, lk_oe, lk_o, lk_in}, {29'h0, 2'b00, lk_drv}, "lock pin");
         d = 8'($urandom);
         xfer(1'b1, ddpc_pkg::IDX_DEV_DISABLE, d, r);
         if (!(f == 2'h1 && i < 4)) begin
            cur = d & 8'hF9;
         end
         xfer(1'b0, ddpc_pkg::IDX_DEV_DISABLE, 8'h00, r);
         chk(r, {24'h0, cur}, "lock");
      end
      end_sim();
   end
endmodule : tb
`default_nettype wire
